//--- rtl/cdlo_regs.svh
// register offsets, field positions, reset values and command codes
// assumes inclusion from the design modules only
`ifndef CDLO_REGS_SVH
`define CDLO_REGS_SVH
`define CDLO_DIR_OFFSET       16'h8017
`define CDLO_OVL_OFFSET       16'h8018
`define CDLO_DIR_RESET        8'h00
`define CDLO_OVL_RESET        8'h00
`define CDLO_DIR_LSB          0
`define CDLO_DIR_MSB          1
`define CDLO_MX_LSB           0
`define CDLO_MX_MSB           1
`define CDLO_BLK1_BIT         2
`define CDLO_BLK3_BIT         3
`define CDLO_OV_BIT           4
`define CDLO_DIR_USED_MASK    8'h03
`define CDLO_OVL_USED_MASK    8'h1f
`define CDLO_CMD_RIGHT        8'h4c
`define CDLO_CMD_LEFT         8'h4d
`define CDLO_CMD_UP           8'h4e
`define CDLO_CMD_DOWN         8'h4f
`define CDLO_CMD_OVERLAY      8'h5b
`endif

//--- rtl/cdlo_pkg.sv
// types shared by the cursor direction and layer overlay block
// assumes nothing of its surroundings
package cdlo_pkg;
  typedef enum logic [1:0]
  {
    CDLO_DIR_RIGHT = 2'h0,
    CDLO_DIR_LEFT  = 2'h1,
    CDLO_DIR_UP    = 2'h2,
    CDLO_DIR_DOWN  = 2'h3
  } cdlo_dir_t;

  typedef enum logic [1:0]
  {
    CDLO_MX_OR  = 2'h0,
    CDLO_MX_XOR = 2'h1,
    CDLO_MX_AND = 2'h2,
    CDLO_MX_RSV = 2'h3
  } cdlo_mx_t;

  typedef struct packed
  {
    logic     three_layer_select;
    logic     block3_graphics_select;
    logic     block1_graphics_select;
    cdlo_mx_t composition_method;
  } cdlo_ovl_t;

  typedef struct packed
  {
    logic [7:0] l1;
    logic [7:0] l2;
    logic [7:0] l3;
  } cdlo_pix_t;
endpackage

//--- rtl/cdlo_step.sv
// cursor address stepping unit
// assumes pitch is stable while an access strobe is applied
`timescale 1ns/10ps
`default_nettype none
`include "cdlo_regs.svh"
module cdlo_step
  import cdlo_pkg::*;
#(
  parameter int AW = 16
)
(
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] pitch,
  input  wire cdlo_dir_t     dir,
  output logic      [AW-1:0] addr_next
);
  if (AW < 2)
  begin
    $error("cdlo_step: AW too small");
  end

  // wraps modulo the address space
  always_comb
  begin
    unique case (dir)
      CDLO_DIR_RIGHT: addr_next = addr + AW'(1);  // RL3 RL18
      CDLO_DIR_LEFT:  addr_next = addr - AW'(1);  // RL3 RL18
      CDLO_DIR_UP:    addr_next = addr - pitch;   // RL4 RL18
      CDLO_DIR_DOWN:  addr_next = addr + pitch;   // RL4 RL18
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/cdlo_mix.sv
// per pixel layer composition
// assumes pixel bytes of the three layers arrive aligned
`timescale 1ns/10ps
`default_nettype none
`include "cdlo_regs.svh"
module cdlo_mix
  import cdlo_pkg::*;
(
  input  wire cdlo_pix_t  pix,
  input  wire cdlo_mx_t   method,
  input  wire logic       use_l3,
  output logic      [7:0] out
);
  logic [7:0] l3;

  always_comb
  begin
    l3 = use_l3 ? pix.l3 : 8'h00;  // RL7
    // one method for the whole layer, whatever block it spans
    unique case (method)                               // RL13
      CDLO_MX_OR:  out = pix.l1 | pix.l2 | l3;         // RL12
      CDLO_MX_XOR: out = (pix.l1 ^ pix.l2) | l3;       // RL12
      CDLO_MX_AND: out = (pix.l1 & pix.l2) | l3;       // RL12
      CDLO_MX_RSV: out = pix.l1 | pix.l2 | l3;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/cdlo_top.sv
// cursor direction and layer overlay control
// assumes host strobes are one cycle and synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "cdlo_regs.svh"
// Notes on behaviour
// RL1: direction field 00 right, 01 left, 10 up, 11 down.
// RL2: indirect commands 4c to 4f select right, left, up, down.
// RL3: left and right moves step the address by one.
// RL4: up and down moves step the address by the pitch.
// RL5: every display memory read or write advances the address.
// RL6: host presets increments itself for nine-pixel characters.
// RL7: three-layer bit picks two or three layers in graphics.
// RL8: host clears three-layer bit when mixing text and graphics.
// RL9: block 3 is text when its bit is 0, graphics when 1.
// RL10: blocks 2 and 4 are always graphics.
// RL11: block 1 is text when its bit is 0, graphics when 1.
// RL12: method 00 or-or, 01 xor-or, 10 and-or, 11 reserved.
// RL13: one composition method serves both blocks of a layer.
// RL14: host avoids third layer when first layer is text.
// RL15: layers two and three are graphics only.
// RL16: direction command carries and applies the direction value.
// RL17: overlay command parameter loads composition and block modes.
// RL18: add or subtract one or pitch, wrapping at 16 bits.
module cdlo_top
  import cdlo_pkg::*;
#(
  parameter int AW = 16
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_code,
  input  wire logic          param_valid,
  input  wire logic [7:0]    param_data,
  input  wire logic          cursor_load,
  input  wire logic [AW-1:0] cursor_load_addr,
  input  wire logic          mem_access,
  input  wire logic [AW-1:0] pitch,
  output logic      [AW-1:0] cursor_addr,
  input  wire cdlo_pix_t     pix,
  input  wire logic [1:0]    pix_block,
  output logic      [7:0]    pix_out,
  output logic               block_graphics,
  output cdlo_dir_t          cursor_direction,
  output cdlo_ovl_t          overlay_cfg
);
  if (AW != 16)
  begin
    $error("cdlo_top: address space must be 16 bits");
  end

  // ****************************************
  // register state
  // ****************************************
  logic [7:0]    cursor_step_direction_r;
  logic [7:0]    cursor_step_direction_nxt;
  logic [7:0]    layer_overlay_control_r;
  logic [7:0]    layer_overlay_control_nxt;
  logic          ovl_wait_r;
  logic          ovl_wait_nxt;
  logic [AW-1:0] cursor_r;
  logic [AW-1:0] cursor_nxt;
  logic [AW-1:0] step_addr;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  logic [7:0]    pix_r;
  logic [7:0]    pix_nxt;
  logic [7:0]    mix_out;
  logic          gfx_r;
  logic          gfx_nxt;
  logic          gfx_now;
  cdlo_ovl_t     ovl;

  assign ovl = cdlo_ovl_t'(layer_overlay_control_r[4:0]);

  always_comb
  begin
    cursor_step_direction_nxt = cursor_step_direction_r;
    layer_overlay_control_nxt = layer_overlay_control_r;
    ovl_wait_nxt              = ovl_wait_r;
    if (reg_wr && reg_addr == `CDLO_DIR_OFFSET)
      cursor_step_direction_nxt = reg_wdata & `CDLO_DIR_USED_MASK;
    if (reg_wr && reg_addr == `CDLO_OVL_OFFSET)
      layer_overlay_control_nxt = reg_wdata & `CDLO_OVL_USED_MASK;
    if (param_valid && ovl_wait_r)
    begin
      layer_overlay_control_nxt = param_data & `CDLO_OVL_USED_MASK; // RL17
      ovl_wait_nxt              = 1'b0;
    end
    if (cmd_valid)
    begin
      ovl_wait_nxt = 1'b0;
      unique case (cmd_code)
        `CDLO_CMD_RIGHT: cursor_step_direction_nxt = 8'h00; // RL2 RL16
        `CDLO_CMD_LEFT:  cursor_step_direction_nxt = 8'h01; // RL2 RL16
        `CDLO_CMD_UP:    cursor_step_direction_nxt = 8'h02; // RL2 RL16
        `CDLO_CMD_DOWN:  cursor_step_direction_nxt = 8'h03; // RL2 RL16
        `CDLO_CMD_OVERLAY: ovl_wait_nxt = 1'b1;             // RL17
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cursor_step_direction_r <= `CDLO_DIR_RESET;
      layer_overlay_control_r <= `CDLO_OVL_RESET;
      ovl_wait_r              <= 1'b0;
    end
    else if (clk_en)
    begin
      cursor_step_direction_r <= cursor_step_direction_nxt;
      layer_overlay_control_r <= layer_overlay_control_nxt;
      ovl_wait_r              <= ovl_wait_nxt;
    end
  end

  // ****************************************
  // cursor address
  // ****************************************
  assign cursor_direction =
    cdlo_dir_t'(cursor_step_direction_r[`CDLO_DIR_MSB:`CDLO_DIR_LSB]);  // RL1

  cdlo_step #(
    .AW        (AW)
  ) u_step (
    .addr      (cursor_r),
    .pitch     (pitch),
    .dir       (cursor_direction),
    .addr_next (step_addr)
  );

  always_comb
  begin
    cursor_nxt = cursor_r;
    if (cursor_load)
      cursor_nxt = cursor_load_addr;
    else if (mem_access)
      cursor_nxt = step_addr;  // RL5
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cursor_r <= '0;
    else if (clk_en)
      cursor_r <= cursor_nxt;
  end

  assign cursor_addr = cursor_r;

  // ****************************************
  // register read
  // ****************************************
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      if (reg_addr == `CDLO_DIR_OFFSET)
        rdata_nxt = cursor_step_direction_r;
      else if (reg_addr == `CDLO_OVL_OFFSET)
        rdata_nxt = layer_overlay_control_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (clk_en)
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // layer composition
  // ****************************************
  always_comb
  begin
    unique case (pix_block)
      2'h0: gfx_now = ovl.block1_graphics_select;   // RL11
      2'h2: gfx_now = ovl.block3_graphics_select;   // RL9
      default: gfx_now = 1'b1;                      // RL10 RL15
    endcase
  end

  cdlo_mix u_mix (
    .pix    (pix),
    .method (ovl.composition_method),
    .use_l3 (ovl.three_layer_select),
    .out    (mix_out)
  );

  always_comb
  begin
    pix_nxt = mix_out;
    gfx_nxt = gfx_now;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pix_r <= 8'h00;
      gfx_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pix_r <= pix_nxt;
      gfx_r <= gfx_nxt;
    end
  end

  assign pix_out        = pix_r;
  assign block_graphics = gfx_r;
  assign overlay_cfg    = ovl;
endmodule
`default_nettype wire

//--- test/cdlo_monitor.sv
// port checker for cdlo_top
// assumes a bind onto cdlo_top
`timescale 1ns/10ps
`default_nettype none
module cdlo_monitor
  import cdlo_pkg::*;
#(
  parameter int AW = 16
)
(
  input wire logic      clk_sys,
  input wire logic      rst,
  input wire logic      clk_en,
  input wire logic      cmd_valid,
  input wire logic[7:0] cmd_code,
  input wire logic      param_valid,
  input wire logic[7:0] param_data,
  input wire logic      cursor_load,
  input wire logic      mem_access,
  input wire logic[AW-1:0] pitch,
  input wire logic[AW-1:0] cursor_addr,
  input wire cdlo_pix_t pix,
  input wire logic[1:0] pix_block,
  input wire logic[7:0] pix_out,
  input wire logic      block_graphics,
  input wire cdlo_dir_t cursor_direction,
  input wire cdlo_ovl_t overlay_cfg
);
  logic [7:0] l3_m;
  logic [7:0] mix_m;
  logic       bsel_m;
  always_comb
  begin
    l3_m = overlay_cfg.three_layer_select ? pix.l3 : 8'h00;
    bsel_m = pix_block[1] ? overlay_cfg.block3_graphics_select
                          : overlay_cfg.block1_graphics_select;
    case (overlay_cfg.composition_method)
      CDLO_MX_XOR: mix_m = (pix.l1 ^ pix.l2) | l3_m;
      CDLO_MX_AND: mix_m = (pix.l1 & pix.l2) | l3_m;
      default:     mix_m = pix.l1 | pix.l2 | l3_m;
    endcase
  end
  // overlay command waiting for its parameter byte
  logic       pend_m;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pend_m <= 1'b0;
    else if (clk_en && cmd_valid)
      pend_m <= cmd_code == 8'h5b;
    else if (clk_en && param_valid)
      pend_m <= 1'b0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_dir_cmd;
    clk_en && cmd_valid && cmd_code[7:2] == 6'h13
      |=> cursor_direction == $past(cmd_code[1:0]);
  endproperty
  a_dir_cmd: assert property (p_dir_cmd)
    else $error("direction command lost");
  property p_horiz;
    clk_en && mem_access && !cursor_load && !cursor_direction[1]
      |=> cursor_addr == $past(cursor_addr)
          + ($past(cursor_direction[0]) ? 16'hffff : 16'h0001);
  endproperty
  a_horiz: assert property (p_horiz)
    else $error("bad horizontal step");
  property p_vert;
    clk_en && mem_access && !cursor_load && cursor_direction[1]
      |=> cursor_addr == ($past(cursor_direction[0])
          ? $past(cursor_addr) + $past(pitch)
          : $past(cursor_addr) - $past(pitch));
  endproperty
  a_vert: assert property (p_vert)
    else $error("bad vertical step");
  property p_hold;
    !clk_en || !mem_access && !cursor_load |=> $stable(cursor_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("cursor moved without access");
  property p_blk24;
    clk_en && pix_block[0] |=> block_graphics;
  endproperty
  a_blk24: assert property (p_blk24)
    else $error("block 2 or 4 not graphics");
  property p_blk13;
    clk_en && !pix_block[0] |=> block_graphics == $past(bsel_m);
  endproperty
  a_blk13: assert property (p_blk13)
    else $error("block 1 or 3 mode wrong");
  property p_mix;
    clk_en |=> pix_out == $past(mix_m);
  endproperty
  a_mix: assert property (p_mix)
    else $error("pixel composition wrong");
  property p_ovl;
    clk_en && param_valid && pend_m
      |=> overlay_cfg == $past(param_data[4:0]);
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overlay parameter lost");
endmodule
`default_nettype wire

//--- test/cdlo_host.sv
// host cpu model driving strobes and levels
// assumes calls from the bench at a rising edge
`timescale 1ns/10ps
`default_nettype none
module cdlo_host
  import cdlo_pkg::*;
(
  input wire logic clk_sys,
  output var logic clk_en,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [15:0] reg_addr,
  output var logic [7:0] reg_wdata,
  output var logic cmd_valid,
  output var logic [7:0] cmd_code,
  output var logic param_valid,
  output var logic [7:0] param_data,
  output var logic cursor_load,
  output var logic [15:0] cursor_load_addr,
  output var logic mem_access,
  output var logic [15:0] pitch,
  output var cdlo_pix_t pix,
  output var logic [1:0] pix_block
);
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, cmd_valid, cmd_code} = '0;
    {param_valid, param_data, cursor_load, cursor_load_addr} = '0;
    {mem_access, pitch, pix, pix_block} = '0;
    clk_en = 1'b1;
  end
  // one request held n cycles, then released
  task automatic op(input int k, input logic [15:0] a,
                    input logic [23:0] d, input int n);
    @(posedge clk_sys);
    case (k)
      0: reg_wr <= 1'b1;
      1: reg_rd <= 1'b1;
      2: cmd_valid <= 1'b1;
      3: param_valid <= 1'b1;
      4: cursor_load <= 1'b1;
      5: mem_access <= 1'b1;
      6: {clk_en, mem_access} <= 2'b01;
      default: {pix_block, pix} <= {a[1:0], d};
    endcase
    {reg_addr, cursor_load_addr, pitch} <= {a, a, d[15:0]};
    {reg_wdata, cmd_code, param_data} <= {3{d[7:0]}};
    repeat (n) @(posedge clk_sys);
    {reg_wr, reg_rd, cmd_valid, param_valid} <= '0;
    {cursor_load, mem_access, clk_en} <= 3'b001;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for cdlo_top
// assumes cdlo_host as the host and cdlo_monitor bound
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cdlo_pkg::*;
  typedef struct {int due; int sel; logic [15:0] v;} cdlo_exp_t;
  logic clk_sys, rst, clk_en, reg_wr, reg_rd, cmd_valid, param_valid;
  logic cursor_load, mem_access, block_graphics;
  logic [15:0] reg_addr, cursor_load_addr, pitch, cursor_addr, cur, pch;
  logic [7:0] reg_wdata, reg_rdata, cmd_code, param_data, pix_out;
  logic [1:0] pix_block, dir;
  logic [4:0] cfg;
  logic [31:0] rnd = 32'h3e69;
  cdlo_pix_t pix;
  cdlo_dir_t cursor_direction;
  cdlo_ovl_t overlay_cfg;
  cdlo_exp_t q[$];
  cdlo_exp_t e;
  int bad_count, total_checks, cyc;
  cdlo_host u_host (.clk_sys, .clk_en, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .cmd_valid, .cmd_code, .param_valid, .param_data,
    .cursor_load, .cursor_load_addr, .mem_access, .pitch, .pix, .pix_block);
  cdlo_top #(.AW(16)) u_dut (.clk_sys, .rst, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .cmd_valid, .cmd_code, .param_valid,
    .param_data, .cursor_load, .cursor_load_addr, .mem_access, .pitch,
    .cursor_addr, .pix, .pix_block, .pix_out, .block_graphics,
    .cursor_direction, .overlay_cfg);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] mixf(input logic [4:0] c,
                                      input logic [23:0] p);
    logic [7:0] l3;
    l3 = c[4] ? p[7:0] : 8'h00;
    case (c[1:0])
      2'h1: return (p[23:16] ^ p[15:8]) | l3;
      2'h2: return (p[23:16] & p[15:8]) | l3;
      default: return p[23:16] | p[15:8] | l3;
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ex(input int sel, input logic [15:0] v, input int off);
    q.push_back('{cyc + 3 + off, sel, v});
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    cyc = cyc + 1;
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      e = q.pop_front();
      case (e.sel)
        0: chk(cursor_addr, e.v);
        1: chk(16'(pix_out), e.v);
        2: chk(16'(block_graphics), e.v);
        3: chk(16'(reg_rdata), e.v);
        4: chk(16'(cursor_direction), e.v);
        default: chk(16'(overlay_cfg), e.v);
      endcase
    end
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    {clk_sys, rst, bad_count, total_checks, cyc} = {2'b01, 96'h0};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      ex(3, 16'h0, 0);
      u_host.op(1, 16'h8017 + 16'(i), 24'h0, 1);
    end
    for (int i = 0; i < 8; i++)
    begin
      dir = i[1:0];
      ex(4, 16'(dir), 0);
      if (i < 4)
        u_host.op(0, 16'h8017, {22'h3fffff, dir}, 1);
      else
        u_host.op(2, 16'h0, {16'h0, 8'h4c + 8'(dir)}, 1);
      ex(3, 16'(dir), 0);
      u_host.op(1, 16'h8017, 24'h0, 1);
      cur = {16{~(dir[0] ^ dir[1])}};
      rnd = lfsr(rnd);
      pch = rnd[15:0];
      ex(0, cur, 0);
      u_host.op(4, cur, {8'h0, pch}, 1);
      for (int k = 0; k < 3; k++)
      begin
        cur = dir[1] ? (dir[0] ? cur + pch : cur - pch)
                     : (dir[0] ? cur - 16'h1 : cur + 16'h1);
        ex(0, cur, k);
      end
      u_host.op(5, 16'h0, {8'h0, pch}, 3);
      ex(0, cur, 1);
      u_host.op(6, 16'h0, {8'h0, pch}, 2);
    end
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      cfg = rnd[4:0];
      cfg[3:2] = cfg[3:2] | {2{cfg[4]}};
      u_host.op(2, 16'h0, 24'h5b, 1);
      ex(5, 16'(cfg), 0);
      u_host.op(3, 16'h0, {16'h0, 3'h7, cfg}, 1);
      ex(3, 16'(cfg), 0);
      u_host.op(1, 16'h8018, 24'h0, 1);
      for (int j = 0; j < 4; j++)
      begin
        rnd = lfsr(rnd);
        ex(1, 16'(mixf(cfg, rnd[23:0])), 0);
        ex(2, 16'(j[0] | (j[1] ? cfg[3] : cfg[2])), 0);
        u_host.op(7, 16'(j), rnd[23:0], 1);
      end
    end
    ex(5, 16'(cfg), 1);
    u_host.op(3, 16'h0, 24'h1f, 1);
    repeat (4) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
bind cdlo_top cdlo_monitor #(.AW(AW)) u_mon (.clk_sys, .rst, .clk_en,
  .cmd_valid, .cmd_code, .param_valid, .param_data, .cursor_load,
  .mem_access, .pitch, .cursor_addr, .pix, .pix_block, .pix_out,
  .block_graphics, .cursor_direction, .overlay_cfg);
`default_nettype wire
